// ### core/drsr_pkg.sv
`default_nettype none
package drsr_pkg;
	localparam int NUM_BANKS = 8;
	localparam int NUM_SEGS = 8;
	localparam logic [7:0] BANK_MASK_OFFSET = 8'h10;
	localparam logic [7:0] SEG_MASK_OFFSET = 8'h11;
	localparam logic [7:0] SEG_MASK_RSVD_OFFSET = 8'h12;
	localparam logic [7:0] BANK_MASK_RESET = 8'h00;
	localparam logic [7:0] SEG_MASK_RESET = 8'h00;
	localparam int CLK_PERIOD_PS = 4000;
	localparam int CKE_PATH_DELAY_CYCLES = 2;
	// residency and exit interval in ns as plain defaults
	localparam int MIN_SR_RESIDENCY_NS = 15;
	localparam int SR_EXIT_INTERVAL_NS = 140;
	localparam int MIN_SR_RESIDENCY_CYC =
		(MIN_SR_RESIDENCY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int SR_EXIT_INTERVAL_CYC =
		(SR_EXIT_INTERVAL_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	// internal refresh tick interval while in self refresh, 3.9 us
	localparam int SR_REFRESH_INTERVAL_NS = 3900;
	localparam int SR_REFRESH_INTERVAL_CYC = (SR_REFRESH_INTERVAL_NS * 1000) / CLK_PERIOD_PS;
	typedef enum logic [1:0] {DRSR_IDLE, DRSR_ENTRY, DRSR_SELF, DRSR_EXIT} drsr_state_type;
endpackage : drsr_pkg
`default_nettype wire

// ### core/drsr_mask_regs.sv
`default_nettype none
module drsr_mask_regs (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// mode register write
	input wire logic wr_en,
	input wire logic [7:0] wr_addr,
	input wire logic [7:0] wr_data,
	// masks out
	output logic [7:0] bank_refresh_mask,
	output logic [7:0] segment_refresh_mask
);
	logic [7:0] bank_r, bank_nxt, seg_r, seg_nxt;
	always_comb begin
		bank_nxt = bank_r;
		seg_nxt = seg_r;
		if (wr_en && wr_addr == drsr_pkg::BANK_MASK_OFFSET) begin
			bank_nxt = wr_data;
		end
		if (wr_en && wr_addr == drsr_pkg::SEG_MASK_OFFSET) begin
			seg_nxt = wr_data;
		end
		// the reserved offset matches neither, so it changes nothing
	end
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			bank_r <= drsr_pkg::BANK_MASK_RESET;
			seg_r <= drsr_pkg::SEG_MASK_RESET;
		end else begin
			bank_r <= bank_nxt;
			seg_r <= seg_nxt;
		end
	end
	assign bank_refresh_mask = bank_r;
	assign segment_refresh_mask = seg_r;
endmodule // drsr_mask_regs
`default_nettype wire

// ### core/drsr_refresh.sv
`default_nettype none
module drsr_refresh #(
	parameter int SR_REFRESH_INTERVAL = drsr_pkg::SR_REFRESH_INTERVAL_CYC
) (
	// core clock and reset
	input wire logic CORE_CLK,
	input wire logic RST_B,
	// memory pins, asynchronous to the core clock
	input wire logic CK,
	input wire logic CKE,
	input wire logic CS_B,
	input wire logic [9:0] CA,
	// decoded mode register write
	input wire logic MRW_EN,
	input wire logic [7:0] MRW_ADDR,
	input wire logic [7:0] MRW_DATA,
	// status
	output logic SELF_REFRESH,
	output logic RECEIVERS_ON,
	output logic EXIT_BUSY,
	output logic [2:0] PB_BANK,
	output logic REF_PB_PULSE,
	output logic REF_AB_PULSE,
	// internal refresh request during self refresh
	output logic INT_REF_VALID,
	output logic [2:0] INT_REF_BANK,
	output logic [7:0] INT_REF_SEG_EN,
	// per-bank busy mask, other banks stay accessible
	output logic [7:0] BANK_BUSY
);
	logic ck_s1_r, ck_s2_r, ck_d_r;
	logic cke_s1_r, cke_s2_r, cs_s1_r, cs_s2_r;
	logic [9:0] ca_s1_r, ca_s2_r;
	logic cke_prev_r, cke_prev_nxt;
	logic ck_rise;
	logic [7:0] bank_mask, seg_mask;
	drsr_pkg::drsr_state_type state_r, state_nxt;
	logic [15:0] cnt_r, cnt_nxt;
	logic [15:0] tick_r, tick_nxt;
	logic [2:0] pb_r, pb_nxt;
	logic [2:0] ibank_r, ibank_nxt;
	logic [2:0] irb_r, irb_nxt;
	logic ival_r, ival_nxt;
	logic rx_r, rx_nxt;
	logic refpb_r, refpb_nxt, refab_r, refab_nxt;
	logic [7:0] busy_r, busy_nxt;
	logic [7:0] segen_r, segen_nxt;
	logic ref_cmd, sre_cmd;

	// two-stage synchronisers; only stage two is read by logic
	// cke resets low so no command decodes before a link edge has seen it high
	always_ff @(posedge CORE_CLK) begin
		if (!RST_B) begin
			ck_s1_r <= 1'b0;
			ck_s2_r <= 1'b0;
			ck_d_r <= 1'b0;
			cke_s1_r <= 1'b0;
			cke_s2_r <= 1'b0;
			cs_s1_r <= 1'b1;
			cs_s2_r <= 1'b1;
			ca_s1_r <= 10'h000;
			ca_s2_r <= 10'h000;
		end else begin
			ck_s1_r <= CK;
			ck_s2_r <= ck_s1_r;
			ck_d_r <= ck_s2_r;
			cke_s1_r <= CKE;
			cke_s2_r <= cke_s1_r;
			cs_s1_r <= CS_B;
			cs_s2_r <= cs_s1_r;
			ca_s1_r <= CA;
			ca_s2_r <= ca_s1_r;
		end
	end
	assign ck_rise = ck_s2_r && !ck_d_r;

	drsr_mask_regs u_masks (
		.clk(CORE_CLK),
		.rst_b(RST_B),
		.wr_en(MRW_EN && state_r == drsr_pkg::DRSR_IDLE),
		.wr_addr(MRW_ADDR),
		.wr_data(MRW_DATA),
		.bank_refresh_mask(bank_mask),
		.segment_refresh_mask(seg_mask)
	);

	// command decode on the sampled link clock rising edge
	always_comb begin
		ref_cmd = ck_rise && rx_r && cke_s2_r && cke_prev_r && !cs_s2_r
			&& !ca_s2_r[0] && !ca_s2_r[1] && ca_s2_r[2];
		sre_cmd = ck_rise && rx_r && !cke_s2_r && cke_prev_r && !cs_s2_r
			&& !ca_s2_r[0] && !ca_s2_r[1] && ca_s2_r[2];
	end

	always_comb begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		tick_nxt = tick_r;
		pb_nxt = pb_r;
		ibank_nxt = ibank_r;
		irb_nxt = irb_r;
		ival_nxt = 1'b0;
		rx_nxt = rx_r;
		refpb_nxt = 1'b0;
		refab_nxt = 1'b0;
		busy_nxt = 8'h00;
		segen_nxt = segen_r;
		cke_prev_nxt = ck_rise ? cke_s2_r : cke_prev_r;
		unique case (state_r)
			drsr_pkg::DRSR_IDLE: begin
				if (ref_cmd && !ca_s2_r[3]) begin
					refpb_nxt = 1'b1;
					busy_nxt[pb_r] = 1'b1;
					// eighth step wraps to bank 0, one all-bank equivalent
					pb_nxt = pb_r + 3'd1;
				end else if (ref_cmd) begin
					refab_nxt = 1'b1;
					busy_nxt = 8'hff;
					pb_nxt = 3'd0;
				end
				if (sre_cmd) begin
					// controller guarantees banks idle and no pending ops
					state_nxt = drsr_pkg::DRSR_ENTRY;
					cnt_nxt = 16'd0;
				end
			end
			drsr_pkg::DRSR_ENTRY: begin
				// receivers stay on until the cke path delay has passed
				if (ck_rise) begin
					cnt_nxt = cnt_r + 16'd1;
				end
				if (cnt_r == 16'(drsr_pkg::CKE_PATH_DELAY_CYCLES)) begin
					rx_nxt = 1'b0;
					state_nxt = drsr_pkg::DRSR_SELF;
					cnt_nxt = 16'd0;
					// first internal refresh at once, well inside residency
					tick_nxt = 16'(SR_REFRESH_INTERVAL);
				end
			end
			drsr_pkg::DRSR_SELF: begin
				// core-clock timer: link clock may stop here
				if (cnt_r != 16'hffff) begin
					cnt_nxt = cnt_r + 16'd1;
				end
				// the parameter carries the interval in core clock cycles
				if (tick_r >= 16'(SR_REFRESH_INTERVAL)) begin
					tick_nxt = 16'd0;
					ibank_nxt = ibank_r + 3'd1;
					irb_nxt = ibank_r;
					// masked banks get no refresh, segments gated per bank
					ival_nxt = !bank_mask[ibank_r];
					segen_nxt = bank_mask[ibank_r] ? 8'h00 : ~seg_mask;
				end else begin
					tick_nxt = tick_r + 16'd1;
				end
				// a tick on the exit cycle still goes out; later ones are lost
				// only cke is watched while in self refresh
				if (cke_s2_r && cnt_r >= 16'(drsr_pkg::MIN_SR_RESIDENCY_CYC)) begin
					state_nxt = drsr_pkg::DRSR_EXIT;
					cnt_nxt = 16'd0;
					rx_nxt = 1'b1;
				end
			end
			drsr_pkg::DRSR_EXIT: begin
				// starts at the first link edge after cke rose, then runs on core cycles:
				// the interval is a time, so a slow link clock must not stretch it
				if (ck_rise || cnt_r != 16'd0) begin
					cnt_nxt = cnt_r + 16'd1;
				end
				// commands during this interval are ignored, nops expected
				if (cnt_r >= 16'(drsr_pkg::SR_EXIT_INTERVAL_CYC)) begin
					state_nxt = drsr_pkg::DRSR_IDLE;
					pb_nxt = 3'd0;
					ibank_nxt = 3'd0;
				end
			end
		endcase
	end

	always_ff @(posedge CORE_CLK) begin
		if (!RST_B) begin
			state_r <= drsr_pkg::DRSR_IDLE;
			cnt_r <= 16'd0;
			tick_r <= 16'd0;
			pb_r <= 3'd0;
			ibank_r <= 3'd0;
			irb_r <= 3'd0;
			ival_r <= 1'b0;
			rx_r <= 1'b1;
			refpb_r <= 1'b0;
			refab_r <= 1'b0;
			busy_r <= 8'h00;
			segen_r <= 8'h00;
			cke_prev_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			tick_r <= tick_nxt;
			pb_r <= pb_nxt;
			ibank_r <= ibank_nxt;
			irb_r <= irb_nxt;
			ival_r <= ival_nxt;
			rx_r <= rx_nxt;
			refpb_r <= refpb_nxt;
			refab_r <= refab_nxt;
			busy_r <= busy_nxt;
			segen_r <= segen_nxt;
			cke_prev_r <= cke_prev_nxt;
		end
	end

	assign SELF_REFRESH = state_r == drsr_pkg::DRSR_SELF;
	assign EXIT_BUSY = state_r == drsr_pkg::DRSR_EXIT;
	assign RECEIVERS_ON = rx_r;
	assign PB_BANK = pb_r;
	assign REF_PB_PULSE = refpb_r;
	assign REF_AB_PULSE = refab_r;
	assign INT_REF_VALID = ival_r;
	assign INT_REF_BANK = irb_r;
	assign INT_REF_SEG_EN = segen_r;
	assign BANK_BUSY = busy_r;
endmodule // drsr_refresh
`default_nettype wire

// ### testbench/drsr_refresh_sva.sv
`default_nettype none
module drsr_refresh_sva (
	// clock, reset
	input wire logic CORE_CLK,
	input wire logic RST_B,
	// status
	input wire logic SELF_REFRESH,
	input wire logic RECEIVERS_ON,
	input wire logic EXIT_BUSY,
	input wire logic [2:0] PB_BANK,
	input wire logic REF_PB_PULSE,
	input wire logic REF_AB_PULSE,
	input wire logic INT_REF_VALID,
	input wire logic [7:0] BANK_BUSY
);
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (!RST_B);
	one_kind_a: assert property (!(REF_PB_PULSE && REF_AB_PULSE))
		else $error("two kinds");
	rx_off_a: assert property (SELF_REFRESH && $past(SELF_REFRESH) |-> !RECEIVERS_ON)
		else $error("rx on");
	int_in_sr_a: assert property (INT_REF_VALID |-> $past(SELF_REFRESH))
		else $error("int ref");
	cmd_ignored_a: assert property (SELF_REFRESH |-> !(REF_PB_PULSE || REF_AB_PULSE))
		else $error("cmd in sr");
	busy_shape_a: assert property ($onehot0(BANK_BUSY) || BANK_BUSY == 8'hff)
		else $error("busy");
	residency_a: assert property ($rose(SELF_REFRESH) |-> SELF_REFRESH[*4])
		else $error("residency");
	exit_clear_a: assert property ($fell(EXIT_BUSY) |-> PB_BANK == 3'h0)
		else $error("exit bank");
	ab_clear_a: assert property (REF_AB_PULSE |-> ##[0:1] PB_BANK == 3'h0)
		else $error("ab bank");
	entry_rx_a: assert property ($rose(SELF_REFRESH) |-> !RECEIVERS_ON)
		else $error("rx at entry");
	exit_rx_a: assert property (EXIT_BUSY |-> RECEIVERS_ON && !SELF_REFRESH)
		else $error("rx in exit");
	cover property (REF_PB_PULSE);
	cover property (REF_AB_PULSE);
	cover property (INT_REF_VALID);
	cover property ($fell(EXIT_BUSY));
endmodule // drsr_refresh_sva
bind drsr_refresh drsr_refresh_sva i_sva (.CORE_CLK(CORE_CLK), .RST_B(RST_B),
	.SELF_REFRESH(SELF_REFRESH), .RECEIVERS_ON(RECEIVERS_ON), .EXIT_BUSY(EXIT_BUSY),
	.PB_BANK(PB_BANK), .REF_PB_PULSE(REF_PB_PULSE), .REF_AB_PULSE(REF_AB_PULSE),
	.INT_REF_VALID(INT_REF_VALID), .BANK_BUSY(BANK_BUSY));
`default_nettype wire

// ### testbench/drsr_ctrl_model.sv
`default_nettype none
module drsr_ctrl_model (
	// pins toward the device
	output var logic ck,
	output var logic cke,
	output var logic cs_b,
	output var logic [9:0] ca
);
	timeunit 1ns;
	timeprecision 100ps;
	logic run = 1'b1;
	initial begin
		ck = 1'b0;
		cke = 1'b1;
		cs_b = 1'b1;
		ca = 10'h000;
	end
	// halted only inside self refresh
	always #24 ck = run ? ~ck : ck;
	// deselected bus toggles so no stale value lingers
	task automatic nops(input int n);
		repeat (n) begin
			@(negedge ck);
			cs_b = 1'b1;
			ca = ~ca;
		end
	endtask
	task automatic issue(input logic k, input logic [9:0] c, input int n);
		@(negedge ck);
		cke = k;
		cs_b = 1'b0;
		ca = c;
		nops(n);
		run = k;
	endtask
	task automatic exit_sr();
		run = 1'b1;
		nops(3);
		cke = 1'b1;
		// three nops fall short of the exit interval; the caller waits for EXIT_BUSY to drop before the next command
		nops(3);
	endtask
endmodule // drsr_ctrl_model
`default_nettype wire

// ### testbench/test_drsr_refresh.sv
`default_nettype none
module test_drsr_refresh;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk = 1'b0, rst_b = 1'b0, we = 1'b0;
	logic ck, cke, cs_b, sr, rx, xb, pbp, abp, iv, ab;
	logic [9:0] ca;
	logic [2:0] pb, ib;
	logic [7:0] wa = 8'h00, wd = 8'h00, seg, busy;
	logic [15:0] wt [3] = '{16'h1082, 16'h1184, 16'h12ff};
	int miscompares = 0, cmp_count = 0, refs = 0, irefs = 0, eb = 0, mpb = 0;
	integer seed = 32'h36ff48dc;
	always #2 clk = ~clk;
	drsr_ctrl_model i_ctrl (.ck(ck), .cke(cke), .cs_b(cs_b), .ca(ca));
	drsr_refresh #(.SR_REFRESH_INTERVAL(20)) i_dut (.CORE_CLK(clk), .RST_B(rst_b), .CK(ck),
		.CKE(cke), .CS_B(cs_b), .CA(ca), .MRW_EN(we), .MRW_ADDR(wa), .MRW_DATA(wd),
		.SELF_REFRESH(sr), .RECEIVERS_ON(rx), .EXIT_BUSY(xb), .PB_BANK(pb),
		.REF_PB_PULSE(pbp), .REF_AB_PULSE(abp), .INT_REF_VALID(iv), .INT_REF_BANK(ib),
		.INT_REF_SEG_EN(seg), .BANK_BUSY(busy));
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic tally_and_finish();
		$display("compares %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// outputs are looked at mid-cycle, where they have settled
	always @(negedge clk) begin
		refs <= refs + int'(pbp === 1'b1) + int'(abp === 1'b1);
		irefs <= irefs + int'(iv === 1'b1);
		if (iv === 1'b1)
			check(8'h82 & (8'h01 << ib), 8'h00);
		if (iv === 1'b1)
			check(seg, 8'h7b);
		if (pbp === 1'b1) begin
			check(busy, 8'h01 << mpb);
			mpb = (mpb + 1) % 8;
		end
		if (abp === 1'b1) begin
			check(busy, 8'hff);
			mpb = 0;
		end
		if (xb === 1'b1)
			mpb = 0;
	end
	initial begin
		repeat (20000) @(posedge clk);
		$display("timeout at t=%0t", $time);
		miscompares++;
		tally_and_finish();
	end
	initial begin
		repeat (6) @(posedge clk);
		#1 rst_b = 1'b1;
		repeat (4) @(posedge clk);
		for (int i = 1; i <= 12; i++) begin
			// at least one all-bank refresh in every run
			ab = ($random(seed) & 3) == 0 || i == 6;
			eb = ab ? 0 : (eb + 1) % 8;
			// one refresh per six link clocks: none postponed, window kept
			i_ctrl.issue(1'b1, {6'($random(seed)), ab, 3'b100}, 5);
			check(8'(refs), 8'(i));
			check(8'(pb), 8'(eb));
			check(8'(pb), 8'(mpb));
		end
		$display("round robin test done");
		// back-to-back writes, reserved offset last
		foreach (wt[k]) begin
			@(posedge clk);
			#1 we = 1'b1;
			{wa, wd} = wt[k];
		end
		@(posedge clk);
		#1 we = 1'b0;
		// idle banks, nothing in flight, nothing postponed
		i_ctrl.issue(1'b0, 10'h004, 3);
		repeat (300) @(posedge clk);
		check({sr, rx, 6'h00}, 8'h80);
		check(8'(irefs > 3), 8'h01);
		i_ctrl.exit_sr();
		for (int n = 0; xb !== 1'b0; n++) begin
			if (n == 2000) begin
				miscompares++;
				tally_and_finish();
			end
			@(posedge clk);
		end
		check({sr, 4'h0, pb}, 8'h00);
		check(8'(refs), 8'h0c);
		$display("self refresh test done");
		i_ctrl.issue(1'b1, 10'h3c4, 5);
		check({5'h00, pb}, 8'h01);
		check(8'(refs), 8'h0d);
		$display("refresh after exit test done");
		tally_and_finish();
	end
endmodule // test_drsr_refresh
`default_nettype wire
